// file: shared/dsp_decoder_pkg.sv
// Constants, opcode patterns and carrier types of the operand decoder.
// Assumes a 16-bit instruction word and an 8-bit data address.
package dsp_decoder_pkg;
    localparam logic [11:0] OFF_INSTR   = 12'h000;
    localparam logic [11:0] OFF_OPERAND = 12'h004;
    localparam logic [11:0] OFF_ACC_LO  = 12'h008;
    localparam logic [11:0] OFF_ACC_HI  = 12'h00C;
    localparam logic [11:0] OFF_AUX0    = 12'h010;
    localparam logic [11:0] OFF_AUX1    = 12'h014;
    localparam logic [11:0] OFF_STATUS  = 12'h018;
    localparam logic [11:0] OFF_ADDR    = 12'h01C;
    localparam logic [11:0] OFF_STORE   = 12'h020;
    localparam logic [11:0] OFF_MULT    = 12'h024;
    // Instruction fields
    localparam int MODE_BIT  = 7;
    localparam int RSEL_BIT  = 8;
    localparam int S_LSB     = 8;
    localparam int X_LSB     = 8;
    localparam int INC_BIT   = 5;
    localparam int DEC_BIT   = 4;
    localparam int NOSEL_BIT = 3;
    localparam int NEWSEL_BIT = 0;
    localparam logic [4:0] SH_HIGH = 5'h10;
    localparam logic [4:0] SH_CSUB = 5'h0F;
    localparam logic [4:0] SH_MAX  = 5'h10;
    localparam logic [2:0] XS_ONE  = 3'h1;
    localparam logic [2:0] XS_FOUR = 3'h4;
    // Reset values
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [15:0] AUX_RST = 16'h0000;
    localparam logic        SEL_RST = 1'b0;
    localparam logic        PAGE_RST = 1'b0;
    // Opcode patterns
    localparam logic [15:0] PAT_ADD_S  = 16'h0???;
    localparam logic [15:0] PAT_SUB_S  = 16'h1???;
    localparam logic [15:0] PAT_LOAD_S = 16'h2???;
    localparam logic [15:0] PAT_PSAVE  = 16'b0011_000?_????_????;
    localparam logic [15:0] PAT_PFILL  = 16'b0011_100?_????_????;
    localparam logic [15:0] PAT_SAVE_L = 16'h50??;
    localparam logic [15:0] PAT_SAVE_U = 16'b0101_1???_????_????;
    localparam logic [15:0] PAT_ADD_H  = 16'h60??;
    localparam logic [15:0] PAT_PLUS_U = 16'h61??;
    localparam logic [15:0] PAT_SUB_H  = 16'h62??;
    localparam logic [15:0] PAT_MIN_U  = 16'h63??;
    localparam logic [15:0] PAT_CSUB   = 16'h64??;
    localparam logic [15:0] PAT_FILL_U = 16'h65??;
    localparam logic [15:0] PAT_FILL_L = 16'h66??;
    localparam logic [15:0] PAT_PMOD   = 16'h68??;
    localparam logic [15:0] PAT_PG_IMM = 16'h6E??;
    localparam logic [15:0] PAT_PG_FIL = 16'h6F??;
    localparam logic [15:0] PAT_PIMM   = 16'b0111_000?_????_????;
    localparam logic [15:0] PAT_XOR    = 16'h78??;
    localparam logic [15:0] PAT_AND    = 16'h79??;
    localparam logic [15:0] PAT_OR     = 16'h7A??;
    localparam logic [15:0] PAT_ACC_IM = 16'h7E??;
    localparam logic [15:0] PAT_MAG    = 16'h7F88;
    localparam logic [15:0] PAT_CLR    = 16'h7F89;
    localparam logic [15:0] PAT_MUL_IM = 16'b100?_????_????_????;
    localparam logic [15:0] PAT_POLL   = 16'hF600;
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD_S, OP_SUB_S, OP_LOAD_S, OP_PSAVE, OP_PFILL,
        OP_SAVE_L, OP_SAVE_U, OP_ADD_H, OP_PLUS_U, OP_SUB_H, OP_MIN_U,
        OP_CSUB, OP_FILL_U, OP_FILL_L, OP_PMOD, OP_PG_IMM, OP_PG_FIL,
        OP_PIMM, OP_XOR, OP_AND, OP_OR, OP_ACC_IM, OP_MAG, OP_CLR,
        OP_MUL_IM, OP_POLL
    } op_t;
    typedef enum logic [1:0] {
        S_READY = 2'b00, S_SECOND = 2'b01, S_ADDRWORD = 2'b11
    } seq_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } dmem_t;
endpackage

// file: rtl/input_shifter.sv
// Barrel shifter from a memory word into accumulator width.
// Assumes shift codes of 0 to 16; larger codes clamp to 16.
`timescale 1ns/1ps
module input_shifter
    import dsp_decoder_pkg::*;
(
    // Operand in
    input  wire logic [15:0] din,
    input  wire logic [4:0]  shift,
    input  wire logic        sign_ext,
    // Shifted out
    output logic [31:0]      dout
);
    logic [31:0] ext;
    always_comb begin
        ext = {{16{sign_ext & din[15]}}, din};
        // Upper bits extend the sign, vacated low bits fill with zero
        dout = (shift > SH_MAX) ? (ext << SH_MAX) : (ext << shift);
    end
endmodule

// file: rtl/output_shifter.sv
// Accumulator shifter feeding the upper-word store path.
// Assumes only codes 0, 1 and 4 are meaningful; others pass unshifted.
`timescale 1ns/1ps
module output_shifter
    import dsp_decoder_pkg::*;
(
    // Accumulator and shift code
    input  wire logic [31:0] acc,
    input  wire logic [2:0]  code,
    // Upper word after shifting
    output logic [15:0]      upper
);
    logic [31:0] sh;
    always_comb begin
        case (code)
            XS_ONE:  sh = acc << 1;
            XS_FOUR: sh = acc << 4;
            default: sh = acc;
        endcase
        upper = sh[31:16];
    end
endmodule

// file: rtl/dsp_operand_addr_decoder.sv
// Instruction decoder, operand address generator and accumulator.
// Assumes an APB master; operand word stands in a register for the RAM.
`timescale 1ns/1ps
//Contract
// - Without the poll pin, branch-on-poll-low is a two-cycle no-op.
// - Direct address is page bit above seven instruction address bits.
// - Page zero holds 128 words, page one up to 128.
// - Indirect address is low byte of the selected pointer register.
// - Pointer select chooses pointer register zero or one.
// - Indirect ops step the pointer and reload select, no extra cycle.
// - Every data-operand instruction accepts indirect addressing.
// - Immediate forms take operands from the word, never reading RAM.
// - Shift code four bits, store shift three, select one.
// - Shifted add, subtract, load: shift 11..8, mode 7, one cycle.
// - Store upper uses shift bits 10..8, writes shifted upper half.
// - Store lower writes unshifted low half in one cycle.
// - Unsigned add, subtract, fill-low zero-extend the operand.
// - Clear-then-fill-upper clears accumulator, operand into upper half.
// - AND, OR, XOR combine operand with accumulator in one cycle.
// - Magnitude and clear are fixed one-cycle encodings.
// - Immediate forms load accumulator, pointer register and multiplier.
// - Pointer fill and save: select bit 8, mode bit 7.
// - Pointer immediate fill: select bit, low byte value, one cycle.
// - Select loads from immediate; modify steps pointers without data.
// - Page bit loads from memory operand or immediate, one cycle.
// - Accumulator is 32 bits, upper word 31..16, lower 15..0.
// - Input shifter shifts 0 to 16, sign-extends, zero-fills low.
// - Store shifter shifts by 0, 1 or 4 only.
module dsp_operand_addr_decoder
    import dsp_decoder_pkg::*;
#(
    parameter bit HAS_POLL_PIN = 1'b0
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Poll pin, active low
    input  wire logic        poll_input_n,
    // Data memory access and completion
    output dmem_t            dmem,
    output logic             exec_done
);
    logic             ready_q;
    logic             err_q;
    logic [31:0]      prdata_q;
    logic [31:0]      rdata;
    logic             hit;
    logic             stall;
    logic             done_xfer;
    logic             instr_wr;
    logic             issue;
    logic [15:0]      ir;
    op_t              op;
    seq_t             state_q;
    logic [15:0]      instr_q;
    logic [15:0]      operand_q;
    logic [31:0]      acc_q;
    logic [31:0]      acc_d;
    logic [1:0][15:0] aux_q;
    logic [1:0][15:0] aux_d;
    logic             sel_q;
    logic             sel_d;
    logic             page_q;
    logic             page_d;
    logic [15:0]      mult_q;
    logic [15:0]      mult_d;
    dmem_t            dmem_q;
    dmem_t            dmem_d;
    logic             done_q;
    logic             taken_q;
    logic             uses_mem;
    logic             indirect;
    logic [7:0]       dir_addr;
    logic [7:0]       ind_addr;
    logic [7:0]       eff_addr;
    logic [4:0]       shamt;
    logic             sext;
    logic [31:0]      shifted;
    logic [15:0]      upper_sh;
    logic [31:0]      diff;

    function automatic op_t decode_op(input logic [15:0] w);
        casez (w)
            PAT_ADD_S:  return OP_ADD_S;
            PAT_SUB_S:  return OP_SUB_S;
            PAT_LOAD_S: return OP_LOAD_S;
            PAT_PSAVE:  return OP_PSAVE;
            PAT_PFILL:  return OP_PFILL;
            PAT_SAVE_L: return OP_SAVE_L;
            PAT_SAVE_U: return OP_SAVE_U;
            PAT_ADD_H:  return OP_ADD_H;
            PAT_PLUS_U: return OP_PLUS_U;
            PAT_SUB_H:  return OP_SUB_H;
            PAT_MIN_U:  return OP_MIN_U;
            PAT_CSUB:   return OP_CSUB;
            PAT_FILL_U: return OP_FILL_U;
            PAT_FILL_L: return OP_FILL_L;
            PAT_PMOD:   return OP_PMOD;
            PAT_PG_IMM: return OP_PG_IMM;
            PAT_PG_FIL: return OP_PG_FIL;
            PAT_PIMM:   return OP_PIMM;
            PAT_XOR:    return OP_XOR;
            PAT_AND:    return OP_AND;
            PAT_OR:     return OP_OR;
            PAT_ACC_IM: return OP_ACC_IM;
            PAT_MAG:    return OP_MAG;
            PAT_CLR:    return OP_CLR;
            PAT_MUL_IM: return OP_MUL_IM;
            PAT_POLL:   return OP_POLL;
            default:    return OP_NOP;
        endcase
    endfunction

    // APB decode and response
    assign done_xfer = psel & penable & ready_q;
    assign instr_wr  = done_xfer & pwrite & ~err_q & (paddr == OFF_INSTR);
    // Second cycle of a two-cycle op holds off the next instruction
    assign stall = pwrite & (paddr == OFF_INSTR) & (state_q == S_SECOND);

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            OFF_INSTR:   rdata = {16'h0000, instr_q};
            OFF_OPERAND: rdata = {16'h0000, operand_q};
            OFF_ACC_LO:  rdata = {16'h0000, acc_q[15:0]};
            OFF_ACC_HI:  rdata = {16'h0000, acc_q[31:16]};
            OFF_AUX0:    rdata = {16'h0000, aux_q[0]};
            OFF_AUX1:    rdata = {16'h0000, aux_q[1]};
            OFF_STATUS:  rdata = {28'h0000_000, taken_q,
                                  state_q != S_READY, page_q, sel_q};
            OFF_ADDR:    rdata = {22'h00_0000, dmem_q.wr, dmem_q.rd,
                                  dmem_q.addr};
            OFF_STORE:   rdata = {16'h0000, dmem_q.wdata};
            OFF_MULT:    rdata = {16'h0000, mult_q};
            default:     hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && !ready_q && !stall) begin
            ready_q  <= 1'b1;
            // Half-word instruction writes would issue garbage opcodes
            err_q    <= ~hit | (pwrite & (paddr == OFF_INSTR) &
                                ~(pstrb[0] & pstrb[1]));
            prdata_q <= pwrite ? 32'h0000_0000 : rdata;
        end else begin
            ready_q  <= 1'b0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            operand_q <= 16'h0000;
        end else if (done_xfer && pwrite && paddr == OFF_OPERAND) begin
            if (pstrb[0]) begin
                operand_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                operand_q[15:8] <= pwdata[15:8];
            end
        end
    end

    // Decode of the issued word
    assign ir    = pwdata[15:0];
    assign op    = decode_op(ir);
    assign issue = instr_wr & (state_q == S_READY);

    always_comb begin
        case (op)
            OP_ADD_S, OP_SUB_S, OP_LOAD_S, OP_PSAVE, OP_PFILL, OP_SAVE_L,
            OP_SAVE_U, OP_ADD_H, OP_PLUS_U, OP_SUB_H, OP_MIN_U, OP_CSUB,
            OP_FILL_U, OP_FILL_L, OP_PMOD, OP_PG_FIL, OP_XOR, OP_AND,
            OP_OR:   uses_mem = 1'b1;
            default: uses_mem = 1'b0;
        endcase
    end

    // Any operand instruction may use the indirect path
    assign indirect = uses_mem & ir[MODE_BIT];
    assign dir_addr = {page_q, ir[6:0]};
    assign ind_addr = aux_q[sel_q][7:0];
    // Page one covers 128..255, unpopulated words left to the RAM
    assign eff_addr = indirect ? ind_addr : dir_addr;

    always_comb begin
        case (op)
            OP_ADD_S, OP_SUB_S, OP_LOAD_S: shamt = {1'b0, ir[S_LSB +: 4]};
            OP_ADD_H, OP_SUB_H, OP_FILL_U: shamt = SH_HIGH;
            OP_CSUB: shamt = SH_CSUB;
            default: shamt = 5'h00;
        endcase
        sext = !(op == OP_PLUS_U || op == OP_MIN_U || op == OP_FILL_L);
    end

    input_shifter u_in (
        .din      (operand_q),
        .shift    (shamt),
        .sign_ext (sext),
        .dout     (shifted)
    );

    output_shifter u_out (
        .acc   (acc_q),
        .code  (ir[X_LSB +: 3]),
        .upper (upper_sh)
    );

    assign diff = acc_q - shifted;

    always_comb begin
        acc_d  = acc_q;
        aux_d  = aux_q;
        sel_d  = sel_q;
        page_d = page_q;
        mult_d = mult_q;
        dmem_d = '{addr: dmem_q.addr, rd: 1'b0, wr: 1'b0,
                   wdata: dmem_q.wdata};
        if (issue) begin
            if (indirect) begin
                // Step and select update ride along the same cycle
                if (ir[INC_BIT] && !ir[DEC_BIT]) begin
                    aux_d[sel_q] = aux_q[sel_q] + 16'h0001;
                end else if (ir[DEC_BIT] && !ir[INC_BIT]) begin
                    aux_d[sel_q] = aux_q[sel_q] - 16'h0001;
                end
                if (!ir[NOSEL_BIT]) begin
                    sel_d = ir[NEWSEL_BIT];
                end
            end
            if (uses_mem && op != OP_PMOD) begin
                dmem_d.addr = eff_addr;
                dmem_d.rd   = 1'b1;
            end
            case (op)
                OP_ADD_S, OP_ADD_H, OP_PLUS_U: acc_d = acc_q + shifted;
                OP_SUB_S, OP_SUB_H, OP_MIN_U:  acc_d = acc_q - shifted;
                OP_LOAD_S, OP_FILL_U, OP_FILL_L: acc_d = shifted;
                OP_CSUB: begin
                    acc_d = diff[31] ? {acc_q[30:0], 1'b0}
                                     : {diff[30:0], 1'b1};
                end
                OP_AND: acc_d = acc_q & {16'h0000, operand_q};
                OP_OR:  acc_d = acc_q | {16'h0000, operand_q};
                OP_XOR: acc_d = acc_q ^ {16'h0000, operand_q};
                OP_ACC_IM: acc_d = {24'h00_0000, ir[7:0]};
                OP_MAG: acc_d = acc_q[31] ? (~acc_q + 32'h0000_0001)
                                          : acc_q;
                OP_CLR: acc_d = ACC_RST;
                OP_SAVE_U: begin
                    dmem_d.rd    = 1'b0;
                    dmem_d.wr    = 1'b1;
                    dmem_d.wdata = upper_sh;
                end
                OP_SAVE_L: begin
                    dmem_d.rd    = 1'b0;
                    dmem_d.wr    = 1'b1;
                    dmem_d.wdata = acc_q[15:0];
                end
                OP_PSAVE: begin
                    // Stores the value from before any stepping
                    dmem_d.rd    = 1'b0;
                    dmem_d.wr    = 1'b1;
                    dmem_d.wdata = aux_q[ir[RSEL_BIT]];
                end
                // A load wins over a step of the same register
                OP_PFILL: aux_d[ir[RSEL_BIT]] = operand_q;
                OP_PIMM: aux_d[ir[RSEL_BIT]] = {8'h00, ir[7:0]};
                OP_PG_FIL: page_d = operand_q[0];
                OP_PG_IMM: page_d = ir[0];
                OP_MUL_IM: mult_d = {{3{ir[12]}}, ir[12:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_q <= ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            aux_q  <= {AUX_RST, AUX_RST};
            sel_q  <= SEL_RST;
            page_q <= PAGE_RST;
        end else begin
            aux_q  <= aux_d;
            sel_q  <= sel_d;
            page_q <= page_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mult_q  <= 16'h0000;
            dmem_q  <= '0;
            instr_q <= 16'h0000;
        end else begin
            mult_q <= mult_d;
            dmem_q <= dmem_d;
            if (issue) begin
                instr_q <= ir;
            end
        end
    end

    assign dmem = dmem_q;

    // Two-cycle poll branch; its address word is swallowed
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= S_READY;
            done_q  <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            done_q <= (issue && op != OP_POLL) || state_q == S_SECOND;
            case (state_q)
                S_READY: begin
                    if (issue && op == OP_POLL) begin
                        state_q <= S_SECOND;
                        taken_q <= HAS_POLL_PIN & ~poll_input_n;
                    end
                end
                S_SECOND: state_q <= S_ADDRWORD;
                S_ADDRWORD: begin
                    if (instr_wr) begin
                        state_q <= S_READY;
                    end
                end
                default: state_q <= S_READY;
            endcase
        end
    end

    assign exec_done = done_q;

    logic [15:0] sel_aux;
    logic [7:0]  aux0_lo;
    logic [7:0]  aux1_lo;
    logic [15:0] acc_lo;
    assign sel_aux = aux_q[sel_q];
    assign aux0_lo = aux_q[0][7:0];
    assign aux1_lo = aux_q[1][7:0];
    assign acc_lo  = acc_q[15:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_direct_addr;
        issue && uses_mem && !ir[MODE_BIT] && op != OP_PMOD
            |=> dmem.addr == $past(dir_addr);
    endproperty
    a_direct_addr: assert property (p_direct_addr)
        else $error("direct address wrong");

    property p_indirect_addr;
        issue && indirect && op != OP_PMOD |=> dmem.addr ==
            ($past(sel_q) ? $past(aux1_lo) : $past(aux0_lo));
    endproperty
    a_indirect_addr: assert property (p_indirect_addr)
        else $error("indirect address wrong");

    property p_poll_two;
        issue && op == OP_POLL |=> !exec_done ##1 exec_done;
    endproperty
    a_poll_two: assert property (p_poll_two)
        else $error("poll branch not two cycles");

    property p_single;
        issue && op != OP_POLL |=> exec_done;
    endproperty
    a_single: assert property (p_single)
        else $error("instruction not single cycle");

    property p_step;
        issue && indirect && ir[INC_BIT] && !ir[DEC_BIT] &&
            ir[NOSEL_BIT] && op == OP_PMOD
            |=> sel_aux == $past(sel_aux) + 16'h0001;
    endproperty
    a_step: assert property (p_step)
        else $error("pointer not incremented");

    property p_imm_noread;
        issue && !uses_mem |=> !dmem.rd && !dmem.wr;
    endproperty
    a_imm_noread: assert property (p_imm_noread)
        else $error("immediate op touched RAM");

    property p_fill_upper;
        issue && op == OP_FILL_U |=> acc_q == {$past(operand_q), 16'h0000};
    endproperty
    a_fill_upper: assert property (p_fill_upper)
        else $error("fill upper wrong");

    property p_fill_lower;
        issue && op == OP_FILL_L |=> acc_q == {16'h0000, $past(operand_q)};
    endproperty
    a_fill_lower: assert property (p_fill_lower)
        else $error("unsigned fill wrong");

    property p_save_lower;
        issue && op == OP_SAVE_L |=> dmem.wr && dmem.wdata == $past(acc_lo);
    endproperty
    a_save_lower: assert property (p_save_lower)
        else $error("save lower wrong");

    property p_page_imm;
        issue && op == OP_PG_IMM |=> page_q == $past(pwdata[0]);
    endproperty
    a_page_imm: assert property (p_page_imm)
        else $error("page immediate wrong");
endmodule

// file: testbench/dsp_operand_addr_decoder_tb.sv
// Self-checking bench for the operand decoder, driven over APB.
// Assumes the design's default variant without the poll pin.
`timescale 1ns/1ps
module dsp_operand_addr_decoder_tb;
    import dsp_decoder_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dmem_t       dmem;
    logic        exec_done;
    int          n_fail = 0;
    int          checked = 0;
    int          n_done = 0;
    int          n_rd = 0;
    int          n_wr = 0;
    int          snap;
    logic [31:0] r;
    logic        e;

    always #5 mclk = ~mclk;

    dsp_operand_addr_decoder dut_u (
        .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .poll_input_n(1'b1),
        .dmem(dmem), .exec_done(exec_done)
    );

    // Pulse counters, so single-cycle strobes are never missed
    always @(posedge mclk) begin
        if (exec_done === 1'b1) n_done++;
        if (dmem.rd === 1'b1) n_rd++;
        if (dmem.wr === 1'b1) n_wr++;
    end

    task automatic results();
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) n_fail++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ex(input logic [15:0] ins);
        apb(1'b1, OFF_INSTR, {16'h0000, ins});
    endtask

    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, r);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0000);
        rd("status", OFF_STATUS, 32'h0000_0000);
        ex(16'h7012);
        ex(16'h7134);
        rd("aux0", OFF_AUX0, 32'h0000_0012);
        rd("aux1", OFF_AUX1, 32'h0000_0034);
        apb(1'b1, OFF_OPERAND, 32'h0000_8001);
        ex(16'h6E01);
        ex(16'h2105);
        // Access strobes last one cycle, so only the address is left to read
        rd("addr", OFF_ADDR, 32'h0000_0085);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0002);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_FFFF);
        ex(16'h20A8);
        rd("addr", OFF_ADDR, 32'h0000_0012);
        rd("aux0", OFF_AUX0, 32'h0000_0013);
        // Decrement, then select pointer one
        ex(16'h2091);
        rd("addr", OFF_ADDR, 32'h0000_0013);
        rd("status", OFF_STATUS, 32'h0000_0003);
        ex(16'h2088);
        rd("addr", OFF_ADDR, 32'h0000_0034);
        ex(16'h6605);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_0000);
        ex(16'h5005);
        rd("store", OFF_STORE, 32'h0000_8001);
        ex(16'h6505);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_8001);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0000);
        ex(16'h5905);
        rd("addr", OFF_ADDR, 32'h0000_0085);
        rd("store", OFF_STORE, 32'h0000_0002);
        ex(16'h3105);
        rd("store", OFF_STORE, 32'h0000_0034);
        chk("wr_count", 32'h0000_0003, 32'(n_wr));
        ex(16'h7F89);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_0000);
        snap = n_rd;
        ex(16'h7E55);
        ex(16'h9001);
        // Step pointer one with no data access
        ex(16'h68A8);
        repeat (2) @(posedge mclk);
        chk("rd_count", 32'(snap), 32'(n_rd));
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0055);
        rd("mult", OFF_MULT, 32'h0000_F001);
        rd("aux1", OFF_AUX1, 32'h0000_0035);
        snap = n_done;
        ex(16'hF600);
        ex(16'h0123);
        repeat (4) @(posedge mclk);
        chk("done_count", 32'(snap + 1), 32'(n_done));
        rd("status", OFF_STATUS, 32'h0000_0003);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0055);
        apb(1'b1, OFF_OPERAND, 32'h0000_00F0);
        ex(16'h7905);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0050);
        ex(16'h7A05);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_00F0);
        ex(16'h7805);
        rd("acc_lo", OFF_ACC_LO, 32'h0000_0000);
        ex(16'h6005);
        apb(1'b1, OFF_OPERAND, 32'h0000_8000);
        // Sign extension here would borrow from the upper word
        ex(16'h6105);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_00F0);
        ex(16'h1005);
        rd("acc_hi", OFF_ACC_HI, 32'h0000_00F1);
        ex(16'h3905);
        rd("aux1", OFF_AUX1, 32'h0000_8000);
        ex(16'h6F05);
        rd("status", OFF_STATUS, 32'h0000_0001);
        apb(1'b0, 12'h030, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, e});
        results();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        results();
    end
endmodule
